// file: shared/adc_sel_defines.svh
`ifndef ADC_SEL_DEFINES_SVH
`define ADC_SEL_DEFINES_SVH

// register byte addresses on the plain register port
`define ADDR_INPUT_REF_SEL 8'h00
`define ADDR_CTRL_STATUS_B 8'h01
`define ADDR_RESULT_LOW 8'h02
`define ADDR_RESULT_HIGH 8'h03
`define ADDR_CONV_STATUS 8'h04

// input_and_reference_select fields
`define REF_SEL_MSB 7
`define REF_SEL_LSB 6
`define LEFT_ALIGN_BIT 5
`define CHAN_LOW_MSB 4
`define CHAN_LOW_LSB 0
`define INPUT_REF_SEL_RESET 8'h00

// converter_control_status_b field
`define CHAN_HIGH_BIT 5
`define CTRL_STATUS_B_RESET 8'h00

// conversion status fields
`define DONE_FLAG_BIT 0
`define BUSY_BIT 1

// reference select codes
`define REF_CODE_EXTERNAL 2'h0
`define REF_CODE_SUPPLY 2'h1
`define REF_CODE_RESERVED 2'h2
`define REF_CODE_INTERNAL 2'h3

// six-bit channel codes with a meaning of their own
`define CHAN_DIFF10_1_0 6'h09
`define CHAN_DIFF200_1_0 6'h0B
`define CHAN_DIFF1_0_1 6'h10
`define CHAN_BANDGAP 6'h1E
`define CHAN_GROUND 6'h1F
`define CHAN_DIFF40_1_0 6'h26
`define CHAN_TEMP 6'h27
`define CHAN_PAIR_FIRST 6'h28

`endif

// file: shared/adc_sel_pkg.sv
package adc_sel_pkg;

    typedef enum logic [1:0] {
        GAIN_1X,
        GAIN_10X,
        GAIN_40X,
        GAIN_200X
    } gain_t;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_SINGLE,
        KIND_DIFF
    } input_kind_t;

    typedef enum logic [2:0] {
        SRC_PIN,
        SRC_BANDGAP,
        SRC_GROUND,
        SRC_TEMP,
        SRC_NONE
    } single_src_t;

endpackage : adc_sel_pkg

// file: hdl/adc_input_select.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "adc_sel_defines.svh"
module adc_input_select (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic conv_busy,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic [1:0] ref_code,
    output logic ref_use_external,
    output logic ref_use_supply,
    output logic ref_use_internal,
    output logic ref_internal_on,
    output logic ref_reserved,
    output logic [5:0] chan_code,
    output adc_sel_pkg::input_kind_t input_kind,
    output adc_sel_pkg::single_src_t single_src,
    output logic [3:0] single_pin,
    output logic [2:0] diff_pos_pin,
    output logic diff_neg_pin,
    output adc_sel_pkg::gain_t diff_gain,
    output logic result_low_byte,
    output logic [7:0] result_low,
    output logic [7:0] result_high,
    output logic conversion_done_flag
);

    logic [7:0] sel_ff;
    logic [7:0] nxt_sel;
    logic [7:0] csb_ff;
    logic [7:0] nxt_csb;
    logic [1:0] ref_applied_ff;
    logic [1:0] nxt_ref_applied;
    logic [5:0] chan_applied_ff;
    logic [5:0] nxt_chan_applied;
    logic [9:0] result_ff;
    logic [9:0] nxt_result;
    logic done_ff;
    logic nxt_done;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic wr_sel;
    logic wr_csb;
    logic wr_status;
    logic left_align;
    logic [5:0] chan_written;

    assign wr_sel = reg_wr && (reg_addr == `ADDR_INPUT_REF_SEL);
    assign wr_csb = reg_wr && (reg_addr == `ADDR_CTRL_STATUS_B);
    assign wr_status = reg_wr && (reg_addr == `ADDR_CONV_STATUS);
    assign left_align = sel_ff[`LEFT_ALIGN_BIT];
    assign chan_written = {csb_ff[`CHAN_HIGH_BIT],
                           sel_ff[`CHAN_LOW_MSB:`CHAN_LOW_LSB]};

    // software-visible registers
    always_comb begin
        nxt_sel = sel_ff;
        nxt_csb = csb_ff;
        if (wr_sel) begin
            nxt_sel = reg_wdata;
        end
        if (wr_csb) begin
            // only the high channel bit is held here
            nxt_csb[`CHAN_HIGH_BIT] = reg_wdata[`CHAN_HIGH_BIT];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel_ff <= `INPUT_REF_SEL_RESET;
            csb_ff <= `CTRL_STATUS_B_RESET;
        end else if (clk_en) begin
            sel_ff <= nxt_sel;
            csb_ff <= nxt_csb;
        end
    end

    // settings seen by the converter; the written copy only lands when
    // idle or at the end of a conversion so the sample is never disturbed
    always_comb begin
        nxt_ref_applied = ref_applied_ff;
        nxt_chan_applied = chan_applied_ff;
        if (conv_done || !conv_busy) begin
            nxt_ref_applied = sel_ff[`REF_SEL_MSB:`REF_SEL_LSB];
            nxt_chan_applied = chan_written;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ref_applied_ff <= `REF_CODE_EXTERNAL;
            chan_applied_ff <= 6'h00;
        end else if (clk_en) begin
            ref_applied_ff <= nxt_ref_applied;
            chan_applied_ff <= nxt_chan_applied;
        end
    end

    // held result and completion flag; a new completion beats a clear
    always_comb begin
        nxt_result = result_ff;
        nxt_done = done_ff;
        if (wr_status && reg_wdata[`DONE_FLAG_BIT]) begin
            nxt_done = 1'b0;
        end
        if (conv_done) begin
            nxt_result = conv_result;
            nxt_done = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            result_ff <= 10'h000;
            done_ff <= 1'b0;
        end else if (clk_en) begin
            result_ff <= nxt_result;
            done_ff <= nxt_done;
        end
    end

    // presentation follows the live alignment bit, no deferral
    always_comb begin
        if (left_align) begin
            result_high = result_ff[9:2];
            result_low = {result_ff[1:0], 6'h00};
        end else begin
            result_high = {6'h00, result_ff[9:8]};
            result_low = result_ff[7:0];
        end
    end

    assign result_low_byte = ~left_align;
    assign conversion_done_flag = done_ff;

    // read data stands one cycle after the strobe; unmapped reads as zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_INPUT_REF_SEL: nxt_rdata = sel_ff;
                `ADDR_CTRL_STATUS_B: nxt_rdata = csb_ff;
                `ADDR_RESULT_LOW: nxt_rdata = result_low;
                `ADDR_RESULT_HIGH: nxt_rdata = result_high;
                `ADDR_CONV_STATUS: begin
                    nxt_rdata = 8'h00;
                    nxt_rdata[`DONE_FLAG_BIT] = done_ff;
                    nxt_rdata[`BUSY_BIT] = conv_busy;
                end
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

    // reference decode of the applied code
    assign ref_code = ref_applied_ff;
    assign ref_use_external = (ref_applied_ff == `REF_CODE_EXTERNAL);
    assign ref_use_supply = (ref_applied_ff == `REF_CODE_SUPPLY);
    assign ref_use_internal = (ref_applied_ff == `REF_CODE_INTERNAL);
    assign ref_reserved = (ref_applied_ff == `REF_CODE_RESERVED);
    // internal reference is off whenever it is not the chosen source
    assign ref_internal_on = ref_use_internal;

    assign chan_code = chan_applied_ff;

    // channel decode of the applied six-bit code
    always_comb begin
        input_kind = adc_sel_pkg::KIND_NONE;
        single_src = adc_sel_pkg::SRC_NONE;
        single_pin = 4'h0;
        diff_pos_pin = 3'h0;
        diff_neg_pin = 1'b0;
        diff_gain = adc_sel_pkg::GAIN_1X;
        if (chan_applied_ff >= `CHAN_PAIR_FIRST) begin
            input_kind = adc_sel_pkg::KIND_DIFF;
            diff_pos_pin = {1'b1, chan_applied_ff[1:0]};
            diff_neg_pin = chan_applied_ff[2];
            case (chan_applied_ff[4:3])
                2'h1: diff_gain = adc_sel_pkg::GAIN_10X;
                2'h2: diff_gain = adc_sel_pkg::GAIN_40X;
                2'h3: diff_gain = adc_sel_pkg::GAIN_200X;
                default: diff_gain = adc_sel_pkg::GAIN_1X;
            endcase
        end else begin
            case (chan_applied_ff)
                6'h00, 6'h01, 6'h04, 6'h05, 6'h06, 6'h07: begin
                    input_kind = adc_sel_pkg::KIND_SINGLE;
                    single_src = adc_sel_pkg::SRC_PIN;
                    single_pin = {1'b0, chan_applied_ff[2:0]};
                end
                6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25: begin
                    input_kind = adc_sel_pkg::KIND_SINGLE;
                    single_src = adc_sel_pkg::SRC_PIN;
                    single_pin = 4'h8 + {1'b0, chan_applied_ff[2:0]};
                end
                `CHAN_BANDGAP: begin
                    input_kind = adc_sel_pkg::KIND_SINGLE;
                    single_src = adc_sel_pkg::SRC_BANDGAP;
                end
                `CHAN_GROUND: begin
                    input_kind = adc_sel_pkg::KIND_SINGLE;
                    single_src = adc_sel_pkg::SRC_GROUND;
                end
                `CHAN_TEMP: begin
                    input_kind = adc_sel_pkg::KIND_SINGLE;
                    single_src = adc_sel_pkg::SRC_TEMP;
                end
                `CHAN_DIFF10_1_0, `CHAN_DIFF200_1_0,
                `CHAN_DIFF40_1_0: begin
                    input_kind = adc_sel_pkg::KIND_DIFF;
                    diff_pos_pin = 3'h1;
                    diff_neg_pin = 1'b0;
                    if (chan_applied_ff == `CHAN_DIFF10_1_0) begin
                        diff_gain = adc_sel_pkg::GAIN_10X;
                    end else if (chan_applied_ff == `CHAN_DIFF200_1_0) begin
                        diff_gain = adc_sel_pkg::GAIN_200X;
                    end else begin
                        diff_gain = adc_sel_pkg::GAIN_40X;
                    end
                end
                `CHAN_DIFF1_0_1: begin
                    input_kind = adc_sel_pkg::KIND_DIFF;
                    diff_pos_pin = 3'h0;
                    diff_neg_pin = 1'b1;
                end
                6'h14, 6'h15, 6'h16, 6'h17: begin
                    input_kind = adc_sel_pkg::KIND_DIFF;
                    diff_pos_pin = {1'b1, chan_applied_ff[1:0]};
                    diff_neg_pin = 1'b1;
                end
                // unavailable codes leave the converter unconnected
                default: input_kind = adc_sel_pkg::KIND_NONE;
            endcase
        end
    end

    a_select_write: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && wr_sel |=> sel_ff == $past(reg_wdata))
        else $error("select register did not take the write");

    a_defer_busy: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && conv_busy && !conv_done |=> $stable(chan_applied_ff)
            && $stable(ref_applied_ff))
        else $error("setting changed during a conversion");

    a_apply_done: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && conv_done |=> chan_applied_ff == $past(chan_written)
            && ref_applied_ff == $past(sel_ff[7:6]))
        else $error("pending setting not applied at completion");

    a_flag_set: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && conv_done |=> conversion_done_flag
            && result_ff == $past(conv_result))
        else $error("done flag or result missing after completion");

    a_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && wr_status && reg_wdata[0] && !conv_done
            |=> !conversion_done_flag)
        else $error("done flag not cleared by write of one");

    a_left_view: assert property (@(posedge clk) disable iff (!rstn)
        left_align |-> result_high == result_ff[9:2]
            && result_low[5:0] == 6'h00)
        else $error("left-justified view wrong");

    a_align_now: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && wr_sel && !reg_wdata[5] && !conv_done
            |=> result_low == $past(result_ff[7:0]))
        else $error("alignment change not immediate");

    a_pair_decode: assert property (@(posedge clk) disable iff (!rstn)
        chan_applied_ff[5:3] == 3'h7 |-> input_kind == adc_sel_pkg::KIND_DIFF
            && diff_gain == adc_sel_pkg::GAIN_200X
            && diff_neg_pin == chan_applied_ff[2])
        else $error("pair code decoded wrongly");

    a_ref_decode: assert property (@(posedge clk) disable iff (!rstn)
        ref_internal_on |-> ref_applied_ff == 2'h3 && !ref_use_external)
        else $error("internal reference on for wrong code");

    a_read_select: assert property (@(posedge clk) disable iff (!rstn)
        clk_en && reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(sel_ff))
        else $error("select register read back wrong");

endmodule : adc_input_select

// file: dv/tb_adc_input_select.sv
`timescale 1ns/1ps
`include "adc_sel_defines.svh"
module tb_adc_input_select;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic conv_busy = 1'b0;
    logic conv_done = 1'b0;
    logic [9:0] conv_result = 10'h000;
    logic [1:0] ref_code;
    logic ref_use_external, ref_use_supply, ref_use_internal;
    logic ref_internal_on, ref_reserved, diff_neg_pin;
    logic result_low_byte, conversion_done_flag;
    logic [5:0] chan_code;
    logic [3:0] single_pin;
    logic [2:0] diff_pos_pin;
    logic [7:0] result_low, result_high, v, sel;
    adc_sel_pkg::input_kind_t input_kind;
    adc_sel_pkg::single_src_t single_src;
    adc_sel_pkg::gain_t diff_gain;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [5:0] r_code[$];
    adc_sel_pkg::input_kind_t r_kind[$];
    adc_sel_pkg::single_src_t r_src[$];
    logic [3:0] r_pin[$];
    logic [2:0] r_pos[$];
    logic r_neg[$];
    adc_sel_pkg::gain_t r_gain[$];

    adc_input_select dut (.clk(clk), .rstn(rstn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_busy(conv_busy),
        .conv_done(conv_done), .conv_result(conv_result),
        .ref_code(ref_code), .ref_use_external(ref_use_external),
        .ref_use_supply(ref_use_supply), .ref_use_internal(ref_use_internal),
        .ref_internal_on(ref_internal_on), .ref_reserved(ref_reserved),
        .chan_code(chan_code), .input_kind(input_kind),
        .single_src(single_src), .single_pin(single_pin),
        .diff_pos_pin(diff_pos_pin), .diff_neg_pin(diff_neg_pin),
        .diff_gain(diff_gain), .result_low_byte(result_low_byte),
        .result_low(result_low), .result_high(result_high),
        .conversion_done_flag(conversion_done_flag));

    always #2 clk = ~clk;

    task wrap_up;
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // whole run is a few hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails = fails + 1;
            wrap_up();
        end
    end

    task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        total_checks = total_checks + 1;
        if (exp !== got) begin
            fails = fails + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task put(input logic [5:0] c, input adc_sel_pkg::input_kind_t k,
             input adc_sel_pkg::single_src_t s, input logic [3:0] p,
             input logic [2:0] ps, input logic n, input adc_sel_pkg::gain_t g);
        r_code.push_back(c);
        r_kind.push_back(k);
        r_src.push_back(s);
        r_pin.push_back(p);
        r_pos.push_back(ps);
        r_neg.push_back(n);
        r_gain.push_back(g);
    endtask : put

    task se(input logic [5:0] c, input adc_sel_pkg::single_src_t s,
            input logic [3:0] p);
        put(c, adc_sel_pkg::KIND_SINGLE, s, p, 3'h0, 1'b0,
            adc_sel_pkg::GAIN_1X);
    endtask : se

    task df(input logic [5:0] c, input logic [2:0] ps, input logic n,
            input adc_sel_pkg::gain_t g);
        put(c, adc_sel_pkg::KIND_DIFF, adc_sel_pkg::SRC_NONE, 4'h0, ps, n, g);
    endtask : df

    initial begin
        se(6'h00, adc_sel_pkg::SRC_PIN, 4'h0);
        se(6'h01, adc_sel_pkg::SRC_PIN, 4'h1);
        se(6'h04, adc_sel_pkg::SRC_PIN, 4'h4);
        se(6'h07, adc_sel_pkg::SRC_PIN, 4'h7);
        se(6'h20, adc_sel_pkg::SRC_PIN, 4'h8);
        se(6'h25, adc_sel_pkg::SRC_PIN, 4'hD);
        se(6'h1E, adc_sel_pkg::SRC_BANDGAP, 4'h0);
        se(6'h1F, adc_sel_pkg::SRC_GROUND, 4'h0);
        se(6'h27, adc_sel_pkg::SRC_TEMP, 4'h0);
        df(6'h09, 3'h1, 1'b0, adc_sel_pkg::GAIN_10X);
        df(6'h0B, 3'h1, 1'b0, adc_sel_pkg::GAIN_200X);
        df(6'h26, 3'h1, 1'b0, adc_sel_pkg::GAIN_40X);
        df(6'h10, 3'h0, 1'b1, adc_sel_pkg::GAIN_1X);
        df(6'h14, 3'h4, 1'b1, adc_sel_pkg::GAIN_1X);
        df(6'h17, 3'h7, 1'b1, adc_sel_pkg::GAIN_1X);
        df(6'h28, 3'h4, 1'b0, adc_sel_pkg::GAIN_10X);
        df(6'h2F, 3'h7, 1'b1, adc_sel_pkg::GAIN_10X);
        df(6'h32, 3'h6, 1'b0, adc_sel_pkg::GAIN_40X);
        df(6'h3D, 3'h5, 1'b1, adc_sel_pkg::GAIN_200X);
        df(6'h3F, 3'h7, 1'b1, adc_sel_pkg::GAIN_200X);
        put(6'h02, adc_sel_pkg::KIND_NONE, adc_sel_pkg::SRC_NONE, 4'h0, 3'h0,
            1'b0, adc_sel_pkg::GAIN_1X);
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("chan_code", 10'h000, chan_code);
        chk("ref_decode", 10'h002, {ref_use_external, ref_internal_on});
        chk("left_align", 10'h001, result_low_byte);
        chk("done_flag", 10'h000, conversion_done_flag);
        rd(`ADDR_INPUT_REF_SEL, v);
        chk("sel_reset", 10'h000, v);
        for (int i = 0; i < r_code.size(); i++) begin
            sel = {i[1:0], i[2], r_code[i][4:0]};
            wr(`ADDR_CTRL_STATUS_B, {2'h0, r_code[i][5], 5'h00});
            wr(`ADDR_INPUT_REF_SEL, sel);
            repeat (2) @(posedge clk);
            #1;
            chk("chan_code", r_code[i], chan_code);
            chk("ref_code", i[1:0], ref_code);
            chk("ref_decode", {i[1:0] == 2'h0, i[1:0] == 2'h1, i[1:0] == 2'h3,
                i[1:0] == 2'h2, i[1:0] == 2'h3}, {ref_use_external,
                ref_use_supply, ref_use_internal, ref_reserved,
                ref_internal_on});
            chk("right_align", !i[2], result_low_byte);
            chk("input_kind", r_kind[i], input_kind);
            chk("gain", r_gain[i], diff_gain);
            if (r_kind[i] == adc_sel_pkg::KIND_SINGLE) begin
                chk("single", {r_src[i], r_pin[i]}, {single_src, single_pin});
            end
            if (r_kind[i] == adc_sel_pkg::KIND_DIFF) begin
                chk("diff", {r_pos[i], r_neg[i]}, {diff_pos_pin, diff_neg_pin});
            end
            rd(`ADDR_INPUT_REF_SEL, v);
            chk("sel_readback", sel, v);
            rd(`ADDR_CTRL_STATUS_B, v);
            chk("high_bit", {2'h0, r_code[i][5], 5'h00}, v);
        end
        // writes while busy must wait for the done pulse
        wr(`ADDR_CTRL_STATUS_B, 8'h00);
        wr(`ADDR_INPUT_REF_SEL, 8'h00);
        // one idle edge so the cleared setting is applied before busy
        @(posedge clk);
        conv_busy <= 1'b1;
        wr(`ADDR_INPUT_REF_SEL, 8'hE9);
        wr(`ADDR_CTRL_STATUS_B, 8'h20);
        repeat (3) @(posedge clk);
        #1;
        chk("held_setting", 10'h000, {ref_code, chan_code});
        chk("left_align", 10'h000, result_low_byte);
        rd(`ADDR_INPUT_REF_SEL, v);
        chk("sel_busy", 10'h0E9, v);
        @(posedge clk);
        conv_done <= 1'b1;
        conv_result <= 10'h270;
        @(posedge clk);
        conv_done <= 1'b0;
        #1;
        chk("done_flag", 10'h001, conversion_done_flag);
        chk("applied", {2'h3, 6'h29}, {ref_code, chan_code});
        chk("left_low", 10'h000, result_low);
        chk("left_high", 10'h09C, result_high);
        wr(`ADDR_INPUT_REF_SEL, 8'h09);
        #1;
        chk("right_result", 10'h270, {result_high[1:0], result_low});
        chk("right_top", 10'h000, result_high[7:2]);
        chk("ref_held", 10'h003, ref_code);
        rd(`ADDR_RESULT_LOW, v);
        chk("result_low_reg", 10'h070, v);
        rd(`ADDR_RESULT_HIGH, v);
        chk("result_high_reg", 10'h002, v);
        rd(`ADDR_CONV_STATUS, v);
        chk("status", 10'h003, v);
        wr(`ADDR_CONV_STATUS, 8'h01);
        #1;
        chk("flag_clear", 10'h000, conversion_done_flag);
        // completion and clear in one cycle: the set wins
        @(posedge clk);
        conv_done <= 1'b1;
        reg_addr <= `ADDR_CONV_STATUS;
        reg_wdata <= 8'h01;
        reg_wr <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        chk("set_beats_clear", 10'h001, conversion_done_flag);
        @(posedge clk);
        conv_busy <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("idle_apply", {2'h0, 6'h29}, {ref_code, chan_code});
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`ADDR_INPUT_REF_SEL, 8'h55);
        clk_en <= 1'b1;
        rd(`ADDR_INPUT_REF_SEL, v);
        chk("frozen_write", 10'h009, v);
        rd(8'h10, v);
        chk("unmapped", 10'h000, v);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset_mid", 10'h000, {chan_code, result_high[1:0],
            conversion_done_flag});
        @(posedge clk);
        rstn <= 1'b1;
        rd(`ADDR_CTRL_STATUS_B, v);
        chk("b_reset", 10'h000, v);
        wrap_up();
    end
endmodule : tb_adc_input_select
